/* File: shared/rtc_pkg.sv */
// Package: constants, field layout and carrier types of the clock SRAM block
package rtc_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SEC_TIME_NS   = 1_000_000_000;
    localparam int SEC_CYCLES    = SEC_TIME_NS / CLK_PERIOD_NS;
    localparam int FLOAT_TIME_NS = 50;
    localparam int FLOAT_CYCLES  = (FLOAT_TIME_NS / CLK_PERIOD_NS < 1) ? 1
                                   : FLOAT_TIME_NS / CLK_PERIOD_NS;
    localparam int REC_TIME_NS   = 1_000_000;
    localparam int REC_CYCLES    = (REC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Address map
    localparam logic [14:0] ADDR_CTRL = 15'h7FF8;
    localparam logic [2:0]  IDX_CTRL  = 3'h0;
    // Control byte fields and reset value
    localparam int          CTRL_SET_BIT  = 7;
    localparam int          CTRL_HALT_BIT = 6;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  TIME_RESET    = 8'h00;
    // BCD field masks per time byte; lowest and highest values, none for minutes or date
    localparam logic [7:0]  MASK_SEC  = 8'h7F;
    localparam logic [7:0]  MASK_MIN  = 8'h7F;
    localparam logic [7:0]  MASK_HR   = 8'h3F;
    localparam logic [7:0]  MASK_DAY  = 8'h07;
    localparam logic [7:0]  MASK_DATE = 8'h3F;
    localparam logic [7:0]  MASK_MON  = 8'h1F;
    localparam logic [7:0]  MASK_YR   = 8'hFF;
    localparam logic [7:0]  MAX_SEC   = 8'h59;
    localparam logic [7:0]  MAX_HR    = 8'h23;
    localparam logic [7:0]  MAX_DAY   = 8'h07;
    localparam logic [7:0]  MAX_MON   = 8'h12;
    localparam logic [7:0]  MAX_YR    = 8'h99;
    localparam logic [7:0]  BCD_ZERO  = 8'h00;
    localparam logic [7:0]  BCD_ONE   = 8'h01;
    // Pins from the host, sampled on ref_clk
    typedef struct packed {
        logic        chip_sel_n;
        logic        wr_strobe_n;
        logic        out_en_n;
        logic [14:0] addr;
        logic [7:0]  data;
    } rtc_bus_in_type;
    // Data pins toward the host
    typedef struct packed {
        logic [7:0] data;
        logic       data_oe_n;
    } rtc_bus_out_type;
    // Seven time bytes, index 1 seconds up to 7 year
    typedef logic [7:1][7:0] rtc_time_type;
endpackage : rtc_pkg

/* File: logic/rtc_sram_mem.sv */
// Byte-wide memory array with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module rtc_sram_mem
    import rtc_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Write port
    input  wire logic        we,
    input  wire logic [14:0] waddr,
    input  wire logic [7:0]  wdata,
    // Read port
    input  wire logic [14:0] raddr,
    output var  logic [7:0]  rdata
);
    logic [7:0] mem [32768];

    // Array and read register; no reset so it maps onto block memory
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : rtc_sram_mem
`default_nettype wire

/* File: logic/rtc_sram_wclk.sv */
// Top: write cycle, power-fail guard, battery flag and clock byte access
// What this block does
// - Write when write strobe and chip select are both low.
// - Write starts at later falling edge, ends at earlier rising edge.
// - Write strobe low releases driven data outputs within 50 ns.
// - Select and strobe falling together keep outputs floating.
// - Power fail: protect memory, float outputs, ignore bus.
// - Power fail mid-write may lose only the addressed byte.
// - Protection and deselect last a recovery time after supply returns.
// - Check battery at power-up, set low-battery flag.
// - Flag set: block first write, clear flag, accept later writes.
// - Read-halt bit D6 of control byte stops visible updates.
// - Halted bytes hold time of the halt; counters keep running.
// - All bytes update together; halt never splits an update.
// - After read-halt clears, updates resume within one second.
// - Set-time bit D7 halts updates so host can load BCD time.
// - Clearing set-time copies time bytes into counters immediately.
// - First update after set-time clears comes within one second.
// - Control and seven time bytes sit at top eight addresses.
// - Without halt, visible bytes refresh from counters every second.
`timescale 1ns/10ps
`default_nettype none
module rtc_sram_wclk
    import rtc_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES,
    parameter int REC_CYC = REC_CYCLES
)
(
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // Host bus
    input  wire rtc_bus_in_type  bus_i,
    output var  rtc_bus_out_type bus_o,
    // Supply and battery monitors
    input  wire logic            power_fail,
    input  wire logic            battery_low,
    // Status
    output var  logic            battery_low_flag
);
    typedef struct packed {
        logic [7:0][7:0] vis;
        rtc_time_type    cnt;
        logic [24:0]     div;
        logic [23:0]     rec;
        logic            rec_busy;
        logic            pf_q;
        logic            pu;
        logic            bat_flag;
        logic            wr_act;
        logic [14:0]     wa;
        logic [7:0]      wd;
        logic            rc;
        logic [2:0]      ra;
        logic [7:0]      dout;
        logic            oe_n;
    } rtc_state_type;

    rtc_state_type s_r;
    rtc_state_type s_nxt;
    logic          deselect;
    logic          wr_now;
    logic          wr_end;
    logic          mem_we;
    logic          halt;
    logic          tick;
    logic          set_fall;
    logic [7:0]    mem_rd;
    rtc_time_type  cnt_adv;

    // One BCD step inside a field; bit 8 is the carry out
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v >= hi) begin
            bcd_inc = {1'b1, lo};
        end else if (v[3:0] == 4'h9) begin
            bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    // Last date of the month in BCD, leap years by the year byte
    function automatic logic [7:0] month_end(input logic [7:0] mon,
                                             input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        unique case (mon)
            8'h02:                      month_end = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default:                    month_end = 8'h31;
        endcase
    endfunction : month_end

    // Counter chain for one second; flag bits above each field are kept
    always_comb begin
        logic [8:0] r;
        logic       cy;
        r = 9'h000;
        cy = 1'b0;
        cnt_adv = s_r.cnt;
        r = bcd_inc(s_r.cnt[1] & MASK_SEC, BCD_ZERO, MAX_SEC);
        cnt_adv[1] = (s_r.cnt[1] & ~MASK_SEC) | r[7:0];
        cy = r[8];
        if (cy) begin
            r = bcd_inc(s_r.cnt[2] & MASK_MIN, BCD_ZERO, MAX_SEC);
            cnt_adv[2] = (s_r.cnt[2] & ~MASK_MIN) | r[7:0];
            cy = r[8];
        end
        if (cy) begin
            r = bcd_inc(s_r.cnt[3] & MASK_HR, BCD_ZERO, MAX_HR);
            cnt_adv[3] = (s_r.cnt[3] & ~MASK_HR) | r[7:0];
            cy = r[8];
        end
        if (cy) begin
            r = bcd_inc(s_r.cnt[4] & MASK_DAY, BCD_ONE, MAX_DAY);
            cnt_adv[4] = (s_r.cnt[4] & ~MASK_DAY) | r[7:0];
            r = bcd_inc(s_r.cnt[5] & MASK_DATE, BCD_ONE,
                        month_end(s_r.cnt[6] & MASK_MON, s_r.cnt[7]));
            cnt_adv[5] = (s_r.cnt[5] & ~MASK_DATE) | r[7:0];
            cy = r[8];
        end
        if (cy) begin
            r = bcd_inc(s_r.cnt[6] & MASK_MON, BCD_ONE, MAX_MON);
            cnt_adv[6] = (s_r.cnt[6] & ~MASK_MON) | r[7:0];
            cy = r[8];
        end
        if (cy) begin
            r = bcd_inc(s_r.cnt[7] & MASK_YR, BCD_ZERO, MAX_YR);
            cnt_adv[7] = r[7:0];
        end
    end

    // Bus qualification; power-fail and recovery override every pin
    assign deselect = power_fail || s_r.rec_busy;
    assign wr_now   = !bus_i.chip_sel_n && !bus_i.wr_strobe_n
                      && !deselect;
    assign wr_end   = s_r.wr_act && !wr_now && !deselect;
    assign mem_we   = wr_end && !s_r.bat_flag && (s_r.wa < ADDR_CTRL);
    assign halt     = s_r.vis[IDX_CTRL][CTRL_SET_BIT]
                      || s_r.vis[IDX_CTRL][CTRL_HALT_BIT];
    assign tick     = (s_r.div == 25'(SEC_CYC - 1));
    assign set_fall = wr_end && !s_r.bat_flag && s_r.wa[14:3] == ADDR_CTRL[14:3]
                      && s_r.wa[2:0] == IDX_CTRL && s_r.vis[IDX_CTRL][CTRL_SET_BIT]
                      && !s_r.wd[CTRL_SET_BIT];

    // Next state of the whole block
    always_comb begin
        s_nxt = s_r;
        s_nxt.pf_q = power_fail;
        // Seconds divider runs free so resumes land within one second
        s_nxt.div = tick ? 25'h0000000 : s_r.div + 25'h0000001;
        // Power-up: battery checked once per rise of the supply
        if (s_r.pu || (s_r.pf_q && !power_fail)) begin
            s_nxt.pu       = 1'b0;
            s_nxt.bat_flag = battery_low;
            s_nxt.rec      = 24'h000000;
        end
        // Recovery time holds protection after supply returns
        if (power_fail) begin
            s_nxt.rec_busy = 1'b1;
            s_nxt.rec      = 24'h000000;
        end else if (s_r.rec_busy) begin
            s_nxt.rec      = s_r.rec + 24'h000001;
            s_nxt.rec_busy = (s_r.rec < 24'(REC_CYC - 1));
        end
        // Capture address and data while the write is open
        s_nxt.wr_act = wr_now;
        if (wr_now) begin
            s_nxt.wa = bus_i.addr;
            s_nxt.wd = bus_i.data;
        end
        // Internal counters never stop, halted or not
        if (tick) begin
            s_nxt.cnt = cnt_adv;
        end
        // Visible bytes all at once; a halt raised now waits a cycle
        if (tick && !halt) begin
            s_nxt.vis[7:1] = cnt_adv;
        end
        // Host write lands after the second update
        if (wr_end) begin
            if (s_r.bat_flag) begin
                s_nxt.bat_flag = 1'b0;
            end else if (s_r.wa[14:3] == ADDR_CTRL[14:3]) begin
                s_nxt.vis[s_r.wa[2:0]] = s_r.wd;
            end
        end
        // Clearing the set-time bit loads the counters at once
        if (set_fall) begin
            s_nxt.cnt = s_r.vis[7:1];
        end
        // Read path: memory or clock byte, two registers deep
        s_nxt.rc   = (bus_i.addr[14:3] == ADDR_CTRL[14:3]);
        s_nxt.ra   = bus_i.addr[2:0];
        s_nxt.dout = s_r.rc ? s_r.vis[s_r.ra] : mem_rd;
        // Drive only in a read; strobe low floats within one cycle
        s_nxt.oe_n = !(!bus_i.chip_sel_n && !bus_i.out_en_n
                       && bus_i.wr_strobe_n && !deselect);
    end

    // State register; reset starts in recovery with a pending check
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r          <= '0;
            s_r.vis[0]   <= CTRL_RESET;
            s_r.vis[7:1] <= {7{TIME_RESET}};
            s_r.rec_busy <= 1'b1;
            s_r.pu       <= 1'b1;
            s_r.oe_n     <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Memory below the clock bytes; lost or blocked writes never reach it
    rtc_sram_mem u_mem (
        .clk   (ref_clk),
        .we    (mem_we),
        .waddr (s_r.wa),
        .wdata (s_r.wd),
        .raddr (bus_i.addr),
        .rdata (mem_rd)
    );

    // Outputs straight from the state register
    assign bus_o.data       = s_r.dout;
    assign bus_o.data_oe_n  = s_r.oe_n;
    assign battery_low_flag = s_r.bat_flag;

    // Checks on the block's own behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_flag_drops;
        ##1 !s_r.bat_flag;
    endsequence

    sequence s_counters_loaded;
        ##1 s_r.cnt == $past(s_r.vis[7:1]);
    endsequence

    a_write_opens: assert property (
        (!bus_i.chip_sel_n && !bus_i.wr_strobe_n && !deselect) |=> s_r.wr_act)
        else $error("write not opened while select and strobe low");

    a_write_commits: assert property (
        (s_r.wr_act && bus_i.wr_strobe_n && !deselect && !s_r.bat_flag
         && s_r.wa < ADDR_CTRL) |-> mem_we)
        else $error("ended write not committed");

    a_strobe_floats: assert property (
        !bus_i.wr_strobe_n |-> ##1 bus_o.data_oe_n)
        else $error("outputs still driven after strobe low");

    a_joint_fall: assert property (
        ($fell(bus_i.chip_sel_n) && $fell(bus_i.wr_strobe_n))
        |-> ##1 bus_o.data_oe_n)
        else $error("outputs driven after joint fall");

    a_pf_protect: assert property (
        power_fail |=> (bus_o.data_oe_n && !s_r.wr_act && !mem_we))
        else $error("bus active during power fail");

    a_recovery_hold: assert property (
        $fell(power_fail) |-> s_r.rec_busy [*2])
        else $error("recovery ended too early");

    a_battery_block: assert property (
        (wr_end && s_r.bat_flag) |-> !mem_we ##0 s_flag_drops)
        else $error("first write not blocked or flag kept");

    a_halt_freeze: assert property (
        (halt && !wr_end) |=> s_r.vis[7:1] == $past(s_r.vis[7:1]))
        else $error("visible time moved while halted");

    a_set_load: assert property (
        set_fall |-> s_counters_loaded)
        else $error("counters not loaded on set-time clear");

    a_tick_refresh: assert property (
        (tick && !halt && !wr_end) |=> s_r.vis[7:1] == $past(cnt_adv))
        else $error("visible time not refreshed on tick");

    a_tick_spacing: assert property (
        s_r.div < 25'(SEC_CYC))
        else $error("second divider out of range");

    // Supply, battery and clock byte checks
    sequence s_supply_up;
        s_r.pu || (s_r.pf_q && !power_fail);
    endsequence

    sequence s_clock_commit;
        wr_end && !s_r.bat_flag && s_r.wa[14:3] == ADDR_CTRL[14:3];
    endsequence

    a_flag_powerup: assert property (
        s_supply_up |=> s_r.bat_flag == $past(battery_low))
        else $error("battery flag not taken at power-up");

    a_flag_clear: assert property (
        $fell(s_r.bat_flag)
        |-> $past(wr_end || s_r.pu || (s_r.pf_q && !power_fail)))
        else $error("battery flag dropped without a write");

    a_rec_blocks: assert property (
        (s_r.rec_busy && !bus_i.chip_sel_n && !bus_i.wr_strobe_n)
        |=> !s_r.wr_act)
        else $error("write opened during recovery");

    a_deselect_float: assert property (
        deselect |=> bus_o.data_oe_n)
        else $error("outputs driven while deselected");

    a_clock_write: assert property (
        s_clock_commit |=> s_r.vis[s_r.wa[2:0]] == $past(s_r.wd))
        else $error("clock byte write lost");

    a_set_freeze: assert property (
        (s_r.vis[IDX_CTRL][CTRL_SET_BIT] && tick && !wr_end)
        |=> s_r.vis[7:1] == $past(s_r.vis[7:1]))
        else $error("visible time moved in set mode");

    a_read_freeze: assert property (
        (s_r.vis[IDX_CTRL][CTRL_HALT_BIT] && tick && !wr_end)
        |=> s_r.vis[7:1] == $past(s_r.vis[7:1]))
        else $error("visible time moved under read halt");

    a_counters_run: assert property (
        (tick && halt && !set_fall) |=> s_r.cnt == $past(cnt_adv))
        else $error("counters stopped while halted");
endmodule : rtc_sram_wclk
`default_nettype wire

/* File: bench/rtc_host_model.sv */
// Host bus model that drives the clock SRAM pins
`timescale 1ns/10ps
`default_nettype none
module rtc_host_model
    import rtc_pkg::*;
(
    // Clock
    input  wire logic            ref_clk,
    // Device pins
    input  wire rtc_bus_out_type bus_o,
    output var  rtc_bus_in_type  bus_i
);
    rtc_bus_in_type pins;
    logic           drv;
    logic [7:0]     hd;

    // Wire level; released lines show the inverted last value, not a lucky match
    always_comb begin
        bus_i = pins;
        bus_i.data = drv ? hd : (bus_o.data_oe_n ? ~hd : bus_o.data);
    end

    // Idle bus from time zero, select kept high while power comes up
    initial begin
        pins = '0;
        pins.chip_sel_n = 1'b1;
        pins.wr_strobe_n = 1'b1;
        pins.out_en_n = 1'b1;
        drv = 1'b0;
        hd = 8'h00;
    end

    // Mode 0 strobe leads, 1 select leads, 2 both fall together
    task automatic wr(input logic [14:0] a, input logic [7:0] d, input int m,
                      input logic oe, output logic seen);
        seen = 1'b0;
        @(posedge ref_clk);
        pins.addr <= a;
        hd <= d;
        drv <= 1'b1;
        pins.out_en_n <= oe;
        pins.wr_strobe_n <= (m == 1);
        pins.chip_sel_n <= (m == 0);
        repeat (3) begin
            @(posedge ref_clk);
            pins.wr_strobe_n <= 1'b0;
            pins.chip_sel_n <= 1'b0;
            #1 seen |= (bus_o.data_oe_n === 1'b0);
        end
        @(posedge ref_clk);
        if (m == 0) pins.chip_sel_n <= 1'b1;
        else pins.wr_strobe_n <= 1'b1;
        @(posedge ref_clk);
        pins.chip_sel_n <= 1'b1;
        pins.wr_strobe_n <= 1'b1;
        pins.out_en_n <= 1'b1;
        @(posedge ref_clk);
        drv <= 1'b0;
    endtask : wr

    // Plain read; data taken once it has settled behind the enable
    task automatic rd(input logic [14:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        pins.addr <= a;
        pins.chip_sel_n <= 1'b0;
        pins.out_en_n <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (bus_o.data_oe_n !== 1'b0 && n < 8);
        @(posedge ref_clk);
        #1 d = bus_o.data;
        @(posedge ref_clk);
        pins.chip_sel_n <= 1'b1;
        pins.out_en_n <= 1'b1;
        @(posedge ref_clk);
    endtask : rd

    // Read, then drop the strobe; reports the enable one edge later
    task automatic rd_strobe(input logic [14:0] a, output logic flt);
        @(posedge ref_clk);
        pins.addr <= a;
        pins.chip_sel_n <= 1'b0;
        pins.out_en_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        hd <= 8'h77;
        drv <= 1'b1;
        pins.wr_strobe_n <= 1'b0;
        @(posedge ref_clk);
        #1 flt = bus_o.data_oe_n;
        repeat (2) @(posedge ref_clk);
        pins.wr_strobe_n <= 1'b1;
        pins.chip_sel_n <= 1'b1;
        pins.out_en_n <= 1'b1;
        @(posedge ref_clk);
        drv <= 1'b0;
    endtask : rd_strobe
endmodule : rtc_host_model
`default_nettype wire

/* File: bench/rtc_sram_wclk_tb_top.sv */
// Self-checking bench for the clock SRAM write and clock byte block
`timescale 1ns/10ps
`default_nettype none
module rtc_sram_wclk_tb_top
    import rtc_pkg::*;
;
    localparam int SEC = 50;
    localparam int REC = 8;
    logic            ref_clk     = 1'b0;
    logic            rst         = 1'b1;
    logic            power_fail  = 1'b0;
    logic            battery_low = 1'b1;
    logic            flag;
    logic            seen;
    logic            pf_drive    = 1'b0;
    logic [7:0]      rv;
    rtc_bus_in_type  bus_i;
    rtc_bus_out_type bus_o;
    int              fail_count  = 0;
    int              checks_done = 0;
    int              cyc         = 0;

    // Clock
    always #25 ref_clk = ~ref_clk;

    rtc_sram_wclk #(.SEC_CYC(SEC), .REC_CYC(REC)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .bus_i(bus_i), .bus_o(bus_o),
        .power_fail(power_fail), .battery_low(battery_low), .battery_low_flag(flag));
    rtc_host_model i_host (.ref_clk(ref_clk), .bus_o(bus_o), .bus_i(bus_i));

    task automatic check(input logic [7:0] got, exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // Poll a clock byte until it moves; bound covers well over one second
    task automatic poll(input logic [14:0] a, input logic [7:0] old, output logic [7:0] nv);
        int n;
        n = 0;
        do begin
            i_host.rd(a, nv);
            n++;
        end while (nv === old && n < SEC);
    endtask : poll

    // Hang guard and watch for driven outputs during a supply failure
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (power_fail && bus_o.data_oe_n === 1'b0) pf_drive <= 1'b1;
        if (cyc == 4000) begin
            fail_count++;
            $display("wrong value at %0t: run timed out", $time);
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check({7'h00, flag}, 8'h01, "battery flag");
        battery_low <= 1'b0;
        repeat (REC) @(posedge ref_clk);
        i_host.wr(15'h0010, 8'h5A, 0, 1'b1, seen);
        check({7'h00, flag}, 8'h00, "flag cleared");
        i_host.rd(15'h0010, rv);
        check({7'h00, rv === 8'h5A}, 8'h00, "first write blocked");
        // Every strobe ordering must commit
        for (int m = 0; m < 3; m++) begin
            i_host.wr(15'h0020 + 15'(m), 8'hA0 + 8'(m), m, 1'b1, seen);
            i_host.rd(15'h0020 + 15'(m), rv);
            check(rv, 8'hA0 + 8'(m), "write mode");
        end
        i_host.wr(15'h0030, 8'h3C, 2, 1'b0, seen);
        check({7'h00, seen}, 8'h00, "outputs stay floating");
        i_host.rd_strobe(15'h0031, seen);
        check({7'h00, seen}, 8'h01, "outputs released");
        // Supply failure: bus ignored, then recovery keeps it locked out
        i_host.wr(15'h0040, 8'h11, 0, 1'b1, seen);
        @(posedge ref_clk) power_fail <= 1'b1;
        i_host.wr(15'h0040, 8'h22, 1, 1'b1, seen);
        i_host.rd(15'h0040, rv);
        check({7'h00, pf_drive}, 8'h00, "floating in power fail");
        @(posedge ref_clk) power_fail <= 1'b0;
        i_host.wr(15'h0040, 8'h33, 0, 1'b1, seen);
        repeat (REC) @(posedge ref_clk);
        i_host.rd(15'h0040, rv);
        check(rv, 8'h11, "protected byte");
        i_host.rd(15'h0021, rv);
        check(rv, 8'hA1, "other byte kept");
        // Load the clock in set mode; unused bits written as zero
        i_host.wr(ADDR_CTRL, 8'h80, 0, 1'b1, seen);
        i_host.wr(15'h7FF9, 8'h58, 0, 1'b1, seen);
        i_host.wr(15'h7FFA, 8'h10, 1, 1'b1, seen);
        repeat (SEC + 10) @(posedge ref_clk);
        i_host.rd(15'h7FF9, rv);
        check(rv, 8'h58, "set mode holds");
        i_host.wr(ADDR_CTRL, 8'h00, 0, 1'b1, seen);
        poll(15'h7FF9, 8'h58, rv);
        check(rv, 8'h59, "first tick");
        poll(15'h7FF9, 8'h59, rv);
        check(rv, 8'h00, "seconds wrap");
        i_host.rd(15'h7FFA, rv);
        check(rv, 8'h11, "minutes carry");
        // Read halt just after a tick, counters run on behind it
        i_host.wr(ADDR_CTRL, 8'h55, 0, 1'b1, seen);
        i_host.rd(ADDR_CTRL, rv);
        check(rv, 8'h55, "control byte");
        repeat (2 * SEC + 20) @(posedge ref_clk);
        i_host.rd(15'h7FF9, rv);
        check(rv, 8'h00, "halted seconds");
        i_host.wr(ADDR_CTRL, 8'h00, 0, 1'b1, seen);
        poll(15'h7FF9, 8'h00, rv);
        check(rv, 8'h04, "counters kept running");
        summarize();
    end
endmodule : rtc_sram_wclk_tb_top
`default_nettype wire
